// *** hw/timer_h_pkg.sv ***
// Constants shared by the dual 8-bit compare timer mode control
package timer_h_pkg;
    // Register byte addresses
    localparam logic [15:0] MODE0_ADDR = 16'hFF69;   // Unit 0 mode register
    localparam logic [15:0] MODE1_ADDR = 16'hFFFA;   // Unit 1 mode register
    localparam logic [7:0]  MODE_RESET = 8'h00;      // Both registers after reset
    localparam logic [7:0]  READ_IDLE  = 8'h00;      // Read data off the map
    // Field positions inside a mode register
    localparam int RUN_BIT = 7;                      // Run enable
    localparam int CKS_LSB = 4;                      // Clock select, 3 bits
    localparam int MD_LSB  = 2;                      // Mode, 2 bits
    localparam int LEV_BIT = 1;                      // Default output level
    localparam int OEN_BIT = 0;                      // Output enable
    // Clock select codes
    localparam logic [2:0] CKS_C0 = 3'h0;
    localparam logic [2:0] CKS_C1 = 3'h1;
    localparam logic [2:0] CKS_C2 = 3'h2;
    localparam logic [2:0] CKS_C3 = 3'h3;
    localparam logic [2:0] CKS_C4 = 3'h4;
    localparam logic [2:0] CKS_C5 = 3'h5;
    localparam logic [2:0] CKS_C6 = 3'h6;
    localparam logic [2:0] CKS_C7 = 3'h7;
    // Prescaler exponents (divide by two to the power)
    localparam int U0_EXP1 = 1;
    localparam int U0_EXP2 = 2;
    localparam int U0_EXP3 = 6;
    localparam int U0_EXP4 = 10;
    localparam int U1_EXP1 = 2;
    localparam int U1_EXP2 = 4;
    localparam int U1_EXP3 = 6;
    localparam int U1_EXP4 = 12;
    localparam int LS_EXP1 = 7;
    localparam int LS_EXP2 = 9;
    localparam int PRE_W   = 12;                     // Peripheral prescaler width
    localparam int LS_W    = 9;                      // Low-speed divider width
    // Operating modes
    typedef enum logic [1:0] {
        MD_INTERVAL = 2'b00,
        MD_CARRIER  = 2'b01,
        MD_PWM      = 2'b10,
        MD_BAD      = 2'b11
    } tmode_e;
    // Compare phase, Gray along period then duty
    typedef enum logic {
        PH_PERIOD = 1'b0,
        PH_DUTY   = 1'b1
    } phase_e;
endpackage

// *** hw/timer_h_unit.sv ***
// One 8-bit compare timer: counter, compare phases, output and request
`timescale 1ns/1ps
module timer_h_unit
    import timer_h_pkg::*;
#(
    parameter bit HAS_CARRIER = 1'b0               // Carrier mode present
)(
    input  wire logic       clk_i,                 // Peripheral clock
    input  wire logic       resetn_i,              // Async reset, active low
    input  wire logic [7:0] mode_i,                // Mode register value
    input  wire logic       tick_i,                // Selected count pulse
    input  wire logic [7:0] period_i,              // Period compare value
    input  wire logic [7:0] duty_i,                // Duty compare value
    input  wire logic       duty_wr_i,             // Duty compare written
    output logic      [7:0] count_o,               // Counter
    output logic            pin_o,                 // Timer output pin
    output logic            irq_o                  // Match request pulse
);
    import timer_h_pkg::*;

    logic       run;                               // Run enable
    logic       lev;                               // Default level
    tmode_e     md;                                // Mode field
    logic       valid_md;                          // Mode is usable here
    logic       m_per;                             // Period match on tick
    logic       m_dut;                             // Duty match on tick
    logic [7:0] cnt_q;                             // Counter
    logic [7:0] duty_q;                            // Duty in use
    logic [7:0] duty_new_q;                        // Written, not yet taken
    logic       pend_q;                            // Duty transfer pending
    logic       level_q;                           // Output flip-flop
    phase_e     ph_q;                              // Compare phase

    assign run      = mode_i[RUN_BIT];
    assign lev      = mode_i[LEV_BIT];
    assign md       = tmode_e'(mode_i[MD_LSB +: 2]);
    assign valid_md = (md == MD_INTERVAL) || (md == MD_PWM)
                    || (HAS_CARRIER && md == MD_CARRIER);
    assign m_per    = run && valid_md && tick_i && cnt_q == period_i;
    assign m_dut    = run && valid_md && tick_i && cnt_q == duty_q;
    assign count_o  = cnt_q;

    // Counter: cleared while stopped, steps on each count pulse
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_q <= 8'h00;
        else if (!run || !valid_md)
            cnt_q <= 8'h00;
        else if (!tick_i)
            cnt_q <= cnt_q;
        else if (ph_q == PH_PERIOD && m_per)
            cnt_q <= 8'h00;
        else if (ph_q == PH_DUTY && m_dut && md == MD_CARRIER)
            cnt_q <= 8'h00;                        // Carrier clears on duty
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // Compare phase for PWM and carrier modes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ph_q <= PH_PERIOD;
        else if (!run || md == MD_INTERVAL)
            ph_q <= PH_PERIOD;
        else if (ph_q == PH_PERIOD && m_per)
            ph_q <= PH_DUTY;
        else if (ph_q == PH_DUTY && m_dut)
            ph_q <= PH_PERIOD;
    end

    // Duty value: taken at once while stopped, else at period match
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            duty_q     <= 8'h00;
            duty_new_q <= 8'h00;
            pend_q     <= 1'b0;
        end
        else if (duty_wr_i)
        begin
            duty_new_q <= duty_i;
            pend_q     <= 1'b1;
        end
        else if (pend_q && (!run || (m_per && ph_q == PH_PERIOD)))
        begin
            duty_q <= duty_new_q;
            pend_q <= 1'b0;
        end
    end

    // Output flip-flop: default level while stopped
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            level_q <= 1'b0;
        else if (!run)
            level_q <= lev;
        else if (md == MD_INTERVAL && m_per)
            level_q <= ~level_q;
        else if (md == MD_PWM && ph_q == PH_PERIOD && m_per)
            level_q <= ~lev;                       // Active level
        else if (md == MD_PWM && ph_q == PH_DUTY && m_dut)
            level_q <= lev;                        // Inactive level
        else if (md == MD_CARRIER && (ph_q == PH_PERIOD ? m_per : m_dut))
            level_q <= ~level_q;
    end

    // Pin and request flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            pin_o <= mode_i[OEN_BIT] & level_q;
            irq_o <= (md != MD_CARRIER && ph_q == PH_PERIOD && m_per)
                  || (md == MD_CARRIER && ph_q == PH_DUTY && m_dut);
        end
    end

    sequence per_hit_s;
        run && md == MD_INTERVAL && tick_i && cnt_q == period_i;
    endsequence

    stop_clears_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !run |=> cnt_q == 8'h00 && !irq_o)
        else $error("stopped timer not cleared");
    interval_hit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        per_hit_s |=> cnt_q == 8'h00 && irq_o && level_q != $past(level_q))
        else $error("interval match effects missing");
    count_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        run && md == MD_INTERVAL && tick_i && cnt_q != period_i
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not step");
    pin_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !mode_i[OEN_BIT] ##1 !mode_i[OEN_BIT] |-> !pin_o)
        else $error("pin driven while disabled");
    stop_level_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !run ##1 !run |-> level_q == $past(lev))
        else $error("default level not held");
endmodule

// *** hw/timer_h_ctrl.sv ***
// Mode control for two 8-bit compare timers with clock selection
`timescale 1ns/1ps
module timer_h_ctrl
    import timer_h_pkg::*;
(
    input  wire logic            clk_i,             // Peripheral clock, 50 MHz
    input  wire logic            resetn_i,          // Async reset, active low
    input  wire logic [15:0]     reg_addr_i,        // Register byte address
    input  wire logic            reg_wr_i,          // Byte write strobe
    input  wire logic [7:0]      reg_wdata_i,       // Byte write data
    input  wire logic            reg_bit_wr_i,      // Single-bit write strobe
    input  wire logic [2:0]      reg_bit_idx_i,     // Bit index of bit write
    input  wire logic            reg_bit_val_i,     // Bit value of bit write
    output logic      [7:0]      reg_rdata_o,       // Read data, one cycle late
    input  wire logic [1:0][7:0] period_cmp_i,      // Period compare per unit
    input  wire logic [1:0][7:0] duty_cmp_i,        // Duty compare per unit
    input  wire logic [1:0]      duty_wr_i,         // Duty compare written
    input  wire logic            other_timer_out_i, // Other timer output
    input  wire logic            low_speed_osc_clock_i, // Low-speed osc clock
    output logic      [1:0]      timer_output_pin_o, // Timer outputs
    output logic      [1:0]      timer_match_irq_o,  // Match request pulses
    output logic      [1:0][7:0] count_o            // Counters
);
    import timer_h_pkg::*;

    logic [7:0]       timer0_mode_ctrl_q;           // Unit 0 mode register
    logic [7:0]       timer1_mode_ctrl_q;           // Unit 1 mode register
    logic [PRE_W-1:0] pre_q;                        // Free prescaler
    logic [PRE_W:0]   tap;                          // Prescaler tick per power
    logic [LS_W-1:0]  ls_cnt_q;                     // Low-speed edge divider
    logic [1:0]       ls_sync_q;                    // Low-speed synchroniser
    logic             ls_prev_q;                    // Low-speed edge history
    logic             ls_edge;                      // Low-speed rising edge
    logic [1:0]       ot_sync_q;                    // Other timer synchroniser
    logic             ot_prev_q;                    // Other timer history
    logic             ot_edge;                      // Other timer rising edge
    logic [1:0]       tick;                         // Count pulse per unit
    logic             sel0;                         // Address hits unit 0
    logic             sel1;                         // Address hits unit 1
    logic             bit_ok;                       // Bit is bit-addressable
    logic [7:0]       mode_reg [2];                 // Modes for unit loop

    assign sel0   = reg_addr_i == MODE0_ADDR;
    assign sel1   = reg_addr_i == MODE1_ADDR;
    assign bit_ok = reg_bit_idx_i == 3'(RUN_BIT)
                 || reg_bit_idx_i == 3'(LEV_BIT)
                 || reg_bit_idx_i == 3'(OEN_BIT);
    assign mode_reg[0] = timer0_mode_ctrl_q;
    assign mode_reg[1] = timer1_mode_ctrl_q;

    // Unit 0 mode register, byte and bit writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timer0_mode_ctrl_q <= MODE_RESET;
        else if (reg_wr_i && sel0)
            timer0_mode_ctrl_q <= reg_wdata_i;
        else if (reg_bit_wr_i && sel0 && bit_ok)
            timer0_mode_ctrl_q[reg_bit_idx_i] <= reg_bit_val_i;
    end

    // Unit 1 mode register, byte and bit writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timer1_mode_ctrl_q <= MODE_RESET;
        else if (reg_wr_i && sel1)
            timer1_mode_ctrl_q <= reg_wdata_i;
        else if (reg_bit_wr_i && sel1 && bit_ok)
            timer1_mode_ctrl_q[reg_bit_idx_i] <= reg_bit_val_i;
    end

    // Registered read port
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= READ_IDLE;
        else if (sel0)
            reg_rdata_o <= timer0_mode_ctrl_q;
        else if (sel1)
            reg_rdata_o <= timer1_mode_ctrl_q;
        else
            reg_rdata_o <= READ_IDLE;
    end

    // Free-running peripheral prescaler
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pre_q <= '0;
        else
            pre_q <= pre_q + PRE_W'(1);
    end

    // One-cycle tick per power of two
    assign tap[0] = 1'b1;
    for (genvar k = 1; k <= PRE_W; k++)
    begin : g_tap
        assign tap[k] = &pre_q[k-1:0];
    end

    // Low-speed clock: two-flop sync, then edge detect
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ls_sync_q <= 2'b00;
            ls_prev_q <= 1'b0;
        end
        else
        begin
            ls_sync_q <= {ls_sync_q[0], low_speed_osc_clock_i};
            ls_prev_q <= ls_sync_q[1];
        end
    end
    assign ls_edge = ls_sync_q[1] & ~ls_prev_q;

    // Low-speed edge divider
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ls_cnt_q <= '0;
        else if (ls_edge)
            ls_cnt_q <= ls_cnt_q + LS_W'(1);
    end

    // Other timer output: two-flop sync, then edge detect
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ot_sync_q <= 2'b00;
            ot_prev_q <= 1'b0;
        end
        else
        begin
            ot_sync_q <= {ot_sync_q[0], other_timer_out_i};
            ot_prev_q <= ot_sync_q[1];
        end
    end
    assign ot_edge = ot_sync_q[1] & ~ot_prev_q;

    // Count pulse selection per unit
    always_comb
    begin
        unique case (timer0_mode_ctrl_q[CKS_LSB +: 3])
            CKS_C0:  tick[0] = tap[0];
            CKS_C1:  tick[0] = tap[U0_EXP1];
            CKS_C2:  tick[0] = tap[U0_EXP2];
            CKS_C3:  tick[0] = tap[U0_EXP3];
            CKS_C4:  tick[0] = tap[U0_EXP4];
            CKS_C5:  tick[0] = ot_edge;
            default: tick[0] = 1'b0;                // Prohibited codes
        endcase
        unique case (timer1_mode_ctrl_q[CKS_LSB +: 3])
            CKS_C0:  tick[1] = tap[0];
            CKS_C1:  tick[1] = tap[U1_EXP1];
            CKS_C2:  tick[1] = tap[U1_EXP2];
            CKS_C3:  tick[1] = tap[U1_EXP3];
            CKS_C4:  tick[1] = tap[U1_EXP4];
            CKS_C5:  tick[1] = ls_edge && (&ls_cnt_q[LS_EXP1-1:0]);
            CKS_C6:  tick[1] = ls_edge && (&ls_cnt_q[LS_EXP2-1:0]);
            CKS_C7:  tick[1] = ls_edge;
        endcase
    end

    // Two timer units, unit 1 with carrier mode
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        timer_h_unit #(
            .HAS_CARRIER (u == 1)
        ) u_unit (
            .clk_i     (clk_i),
            .resetn_i  (resetn_i),
            .mode_i    (mode_reg[u]),
            .tick_i    (tick[u]),
            .period_i  (period_cmp_i[u]),
            .duty_i    (duty_cmp_i[u]),
            .duty_wr_i (duty_wr_i[u]),
            .count_o   (count_o[u]),
            .pin_o     (timer_output_pin_o[u]),
            .irq_o     (timer_match_irq_o[u])
        );
    end

    byte_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reg_wr_i && sel1 |=> timer1_mode_ctrl_q == $past(reg_wdata_i))
        else $error("byte write lost");
    bit_guard_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reg_bit_wr_i && !reg_wr_i && sel0 && !bit_ok |=> $stable(timer0_mode_ctrl_q))
        else $error("non-addressable bit written");
    bit_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reg_bit_wr_i && !reg_wr_i && sel0 && reg_bit_idx_i == 3'(RUN_BIT)
        |=> timer0_mode_ctrl_q[RUN_BIT] == $past(reg_bit_val_i))
        else $error("run bit write lost");
    half_rate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        timer0_mode_ctrl_q[CKS_LSB +: 3] == CKS_C1 && tick[0]
        ##1 timer0_mode_ctrl_q[CKS_LSB +: 3] == CKS_C1 |-> !tick[0])
        else $error("divide by two tick too fast");
    read_back_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sel0 ##1 !$past(reg_wr_i) && !$past(reg_bit_wr_i) |-> reg_rdata_o == timer0_mode_ctrl_q)
        else $error("read data mismatch");
endmodule

// *** bench/test_eight_bit_timer_mode_control.sv ***
// Self-checking bench for the dual 8-bit compare timer mode control
`timescale 1ns/1ps
module test_eight_bit_timer_mode_control;
    import timer_h_pkg::*;
    logic            clk_i;              // Peripheral clock
    logic            resetn_i;           // Async reset, active low
    logic [15:0]     reg_addr_i;         // Register address
    logic            reg_wr_i;           // Byte write strobe
    logic [7:0]      reg_wdata_i;        // Byte write data
    logic            reg_bit_wr_i;       // Bit write strobe
    logic [2:0]      reg_bit_idx_i;      // Bit write index
    logic            reg_bit_val_i;      // Bit write value
    logic [7:0]      reg_rdata_o;        // Read data
    logic [1:0][7:0] period_cmp_i;       // Period compare values
    logic [1:0][7:0] duty_cmp_i;         // Duty compare values
    logic [1:0]      duty_wr_i;          // Duty compare written
    logic            other_timer_out_i;  // Other timer square wave
    logic            low_speed_osc_clock_i; // Low-speed oscillator level
    logic [1:0]      timer_output_pin_o; // Timer outputs
    logic [1:0]      timer_match_irq_o;  // Match requests
    logic [1:0][7:0] count_o;            // Counters
    int              fails;              // Mismatch count
    int              num_checks;         // Comparison count
    int              ph;                 // Phase counter for slow sources

    // Design under test
    timer_h_ctrl DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_bit_wr_i(reg_bit_wr_i),
        .reg_bit_idx_i(reg_bit_idx_i), .reg_bit_val_i(reg_bit_val_i),
        .reg_rdata_o(reg_rdata_o), .period_cmp_i(period_cmp_i), .duty_cmp_i(duty_cmp_i),
        .duty_wr_i(duty_wr_i), .other_timer_out_i(other_timer_out_i),
        .low_speed_osc_clock_i(low_speed_osc_clock_i),
        .timer_output_pin_o(timer_output_pin_o),
        .timer_match_irq_o(timer_match_irq_o), .count_o(count_o));

    // Clock at 50 MHz
    always #10 clk_i = ~clk_i;

    // Slow sources: 50 percent wave of period 6, low-speed clock of period 4
    always @(posedge clk_i)
    begin
        ph <= ph + 1;
        other_timer_out_i <= ((ph % 6) < 3);
        low_speed_osc_clock_i <= ph[1];
    end

    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Address of a unit's mode register
    function automatic logic [15:0] adr(input int u);
        return (u != 0) ? MODE1_ADDR : MODE0_ADDR;
    endfunction

    // Byte write, held one edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Single-bit write, held one edge
    task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_bit_idx_i <= i;
        reg_bit_val_i <= v;
        reg_bit_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_bit_wr_i <= 1'b0;
    endtask

    // Read and compare, data one cycle after address
    task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(what, 16'(exp), 16'(reg_rdata_o));
    endtask

    // Wait a number of settled sample points
    task automatic waitc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Stop by clearing only the run bit, then clear the rest
    task automatic stop(input int u);
        bw(adr(u), 3'd7, 1'b0);
        wr(adr(u), 8'h00);
    endtask

    // Duty compare write for a unit
    task automatic duty(input int u, input logic [7:0] p, input logic [7:0] d);
        @(posedge clk_i);
        period_cmp_i[u] <= p;
        duty_cmp_i[u] <= d;
        duty_wr_i[u] <= 1'b1;
        @(posedge clk_i);
        duty_wr_i[u] <= 1'b0;
    endtask

    // Bounded wait for a match request
    task automatic wait_irq(input int u);
        int n;
        n = 0;
        while (timer_match_irq_o[u] !== 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("irq seen", 16'd1, 16'(timer_match_irq_o[u]));
    endtask

    // Reset state of registers and outputs
    task automatic test_reset;
        chk("pins", 16'h0, 16'(timer_output_pin_o));
        chk("irqs", 16'h0, 16'(timer_match_irq_o));
        chk("counts", 16'h0, 16'(count_o));
        rdc("mode0 reset", MODE0_ADDR, MODE_RESET);
        rdc("mode1 reset", MODE1_ADDR, MODE_RESET);
        $display("reset test done");
    endtask

    // Byte and bit writes, ignored bits, unmapped place
    task automatic test_regs;
        wr(MODE0_ADDR, 8'h5A);
        wr(MODE1_ADDR, 8'h67);
        rdc("mode0 byte", MODE0_ADDR, 8'h5A);
        rdc("mode1 byte", MODE1_ADDR, 8'h67);
        bw(MODE0_ADDR, 3'd0, 1'b1);
        bw(MODE0_ADDR, 3'd4, 1'b0);
        bw(MODE0_ADDR, 3'd1, 1'b0);
        rdc("mode0 bits", MODE0_ADDR, 8'h59);
        wr(MODE0_ADDR, 8'h00);
        wr(MODE1_ADDR, 8'h00);
        wr(16'hFF6A, 8'hFF);
        rdc("unmapped", 16'hFF6A, READ_IDLE);
        rdc("mode0 kept", MODE0_ADDR, 8'h00);
        chk("count stopped", 16'h0, 16'(count_o));
        $display("register test done");
    endtask

    // Interval match, output toggle, stop behaviour
    task automatic test_interval;
        int n;
        duty(0, 8'h02, 8'h00);
        wr(MODE0_ADDR, 8'h01);
        bw(MODE0_ADDR, 3'd7, 1'b1);
        n = 0;
        while (count_o[0] !== 8'h02 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("count reaches period", 16'h2, 16'(count_o[0]));
        waitc(1);
        chk("count cleared", 16'h0, 16'(count_o[0]));
        chk("irq on match", 16'h1, 16'(timer_match_irq_o[0]));
        chk("pin before toggle", 16'h0, 16'(timer_output_pin_o[0]));
        waitc(1);
        chk("irq one cycle", 16'h0, 16'(timer_match_irq_o[0]));
        chk("pin toggled", 16'h1, 16'(timer_output_pin_o[0]));
        bw(MODE0_ADDR, 3'd7, 1'b0);
        waitc(3);
        chk("stop count", 16'h0, 16'(count_o[0]));
        chk("stop pin", 16'h0, 16'(timer_output_pin_o[0]));
        chk("stop irq", 16'h0, 16'(timer_match_irq_o[0]));
        wr(MODE0_ADDR, 8'h00);
        $display("interval test done");
    endtask

    // Default level and output gating on both units
    task automatic test_level;
        for (int u = 0; u < 2; u++)
        begin
            wr(adr(u), 8'h03);
            waitc(3);
            chk("level high", 16'h1, 16'(timer_output_pin_o[u]));
            wr(adr(u), 8'h01);
            waitc(3);
            chk("level low", 16'h0, 16'(timer_output_pin_o[u]));
            wr(adr(u), 8'h02);
            waitc(3);
            chk("gated off", 16'h0, 16'(timer_output_pin_o[u]));
            wr(adr(u), 8'h00);
        end
        $display("level test done");
    endtask

    // Cycles between counter steps for one clock code
    task automatic gap(input int u, input logic [2:0] k, input int exp);
        logic [7:0] c;
        int n;
        @(posedge clk_i);
        period_cmp_i[u] <= 8'hFF;
        wr(adr(u), {1'b1, k, 4'h0});
        for (int s = 0; s < 2; s++)
        begin
            c = count_o[u];
            n = 0;
            while (count_o[u] === c && n < 20000)
            begin
                @(negedge clk_i);
                n++;
            end
        end
        chk("tick gap", 16'(exp), 16'(n));
        stop(u);
    endtask

    // Every permitted clock code of both units
    task automatic test_clocks;
        int g0[6] = '{1, 2, 4, 64, 1024, 6};
        int g1[8] = '{1, 4, 16, 64, 4096, 512, 2048, 4};
        for (int k = 0; k < 6; k++)
            gap(0, 3'(k), g0[k]);
        for (int k = 0; k < 8; k++)
            gap(1, 3'(k), g1[k]);
        $display("clock test done");
    endtask

    // Prohibited modes and codes keep the counter at zero
    task automatic test_bad;
        logic [8:0] bad[5] = '{9'h084, 9'h08C, 9'h0E0, 9'h0F0, 9'h18C};
        for (int i = 0; i < 5; i++)
        begin
            wr(adr(int'(bad[i][8])), bad[i][7:0]);
            waitc(12);
            chk("held count", 16'h0, 16'(count_o[bad[i][8]]));
            stop(int'(bad[i][8]));
        end
        $display("prohibited test done");
    endtask

    // PWM on unit 0: active width of duty plus one
    task automatic test_pwm;
        int hi;
        duty(0, 8'h04, 8'h01);
        wr(MODE0_ADDR, 8'h09);
        bw(MODE0_ADDR, 3'd7, 1'b1);
        wait_irq(0);
        chk("pwm inactive first", 16'h0, 16'(timer_output_pin_o[0]));
        hi = 0;
        repeat (5)
        begin
            @(negedge clk_i);
            hi += int'(timer_output_pin_o[0]);
        end
        chk("pwm active width", 16'h2, 16'(hi));
        stop(0);
        $display("pwm test done");
    endtask

    // Carrier on unit 1: request only at duty match
    task automatic test_carrier;
        int n;
        duty(1, 8'h03, 8'h01);
        wr(MODE1_ADDR, 8'h05);
        bw(MODE1_ADDR, 3'd7, 1'b1);
        wait_irq(1);
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (timer_match_irq_o[1] !== 1'b1 && n < 100);
        chk("carrier irq gap", 16'h6, 16'(n));
        stop(1);
        $display("carrier test done");
    endtask

    // Watchdog over the expected run length
    initial
    begin
        #(50000 * 20);
        fails++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        clk_i = 1'b0;
        resetn_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_wdata_i = 8'h00;
        reg_bit_wr_i = 1'b0;
        reg_bit_idx_i = 3'h0;
        reg_bit_val_i = 1'b0;
        period_cmp_i = '0;
        duty_cmp_i = '0;
        duty_wr_i = 2'b00;
        fails = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        test_reset();
        test_regs();
        test_interval();
        test_level();
        test_clocks();
        test_bad();
        test_pwm();
        test_carrier();
        tally_and_finish();
    end
endmodule
